// [ddr3b_burst_core.sv]
// Burst read and write engine with strobe-domain write capture
`timescale 1ns/1ps
`include "ddr3b_params.svh"

module ddr3b_burst_core #(
   parameter int MEM_COLW = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire ddr3b_pkg::ddr3b_cmd_type cmd,
   input wire logic [1:0] mrBurstLen,
   output logic [31:0] rdDq,
   output logic rdDqOe,
   output logic rdDqsOe,
   input wire logic dqsClk,
   input wire ddr3b_pkg::ddr3b_beat_type wrBeat,
   input wire logic wrBeatValid
);
   import ddr3b_pkg::*;

   localparam int RL_C = `DDR3B_AL + `DDR3B_CL;
   localparam int RL_M4 = RL_C - 4;
   localparam int RL_M2 = RL_C - 2;
   localparam int AW = 3 + MEM_COLW;
   localparam int PD = RL_C - 1;

   logic [15:0] mem [0:(1 << AW) - 1];

   // Command decode
   wire rdFire = cmd.valid & ~cmd.write;
   wire wrFire = cmd.valid & cmd.write;
   wire isBl8 = (mrBurstLen == `DDR3B_MR_BL8) | ((mrBurstLen == `DDR3B_MR_OTF) & cmd.a12);
   wire [AW-1:0] cmdBase = isBl8 ? {cmd.bank, cmd.col[MEM_COLW-1:3], 3'h0} :
      {cmd.bank, cmd.col[MEM_COLW-1:2], 2'h0};

   // Read latency delay line
   logic pipeValid [0:PD-1];
   logic pipeBl8 [0:PD-1];
   logic [AW-1:0] pipeBase [0:PD-1];
   always_ff @(posedge mclk) begin
      pipeValid[0] <= rst ? 1'b0 : rdFire;
      pipeBl8[0] <= isBl8;
      pipeBase[0] <= cmdBase;
   end
   genvar gi;
   generate
      for (gi = 1; gi < PD; gi++) begin : g_pipe
         always_ff @(posedge mclk) begin
            pipeValid[gi] <= rst ? 1'b0 : pipeValid[gi-1];
            pipeBl8[gi] <= pipeBl8[gi-1];
            pipeBase[gi] <= pipeBase[gi-1];
         end
      end
   endgenerate

   // Read burst output
   logic [1:0] rdCnt;
   logic [AW-1:0] rdAddr;
   wire headValid = pipeValid[PD-1];
   wire [AW-1:0] headBase = pipeBase[PD-1];
   wire rdLast = rdCnt == 2'h0;
   wire [AW-1:0] srcAddr = headValid ? headBase : rdAddr;
   wire [31:0] srcPair = {mem[srcAddr + AW'(1)], mem[srcAddr]};
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdDqOe <= 1'b0;
         rdCnt <= 2'h0;
         rdAddr <= '0;
         rdDq <= 32'h0;
      end else if (headValid) begin
         rdDqOe <= 1'b1;
         rdCnt <= pipeBl8[PD-1] ? `DDR3B_BL8_CYC : `DDR3B_BC4_CYC;
         rdAddr <= headBase + AW'(2);
         rdDq <= srcPair;
      end else if (rdDqOe) begin
         rdDqOe <= ~rdLast;
         rdCnt <= rdCnt - 2'h1;
         rdAddr <= rdAddr + AW'(2);
         rdDq <= rdLast ? 32'h0 : srcPair;
      end
   end
   assign rdDqsOe = rdDqOe;

   // Write request toward strobe domain
   logic wrReqTog;
   logic [AW-1:0] wrReqBase;
   logic wrReqBl8;
   always_ff @(posedge mclk) begin
      if (rst) begin
         wrReqTog <= 1'b0;
         wrReqBase <= '0;
         wrReqBl8 <= 1'b0;
      end else if (wrFire) begin
         wrReqTog <= ~wrReqTog;
         wrReqBase <= cmdBase;
         wrReqBl8 <= isBl8;
      end
   end

   // Strobe domain capture
   logic [1:0] lnkRstSync;
   logic [2:0] reqSync;
   logic lnkActive;
   logic lnkBl8;
   logic [2:0] lnkCnt;
   logic [AW-1:0] lnkBase;
   logic lnkDoneTog;
   logic [AW-1:0] doneBase;
   logic doneBl8;
   ddr3b_beat_type lnkBuf [0:`DDR3B_BL8_BEATS-1];
   wire lnkRst = lnkRstSync[1];
   wire lnkNewReq = reqSync[2] ^ reqSync[1];
   wire [2:0] lnkLastIdx = lnkBl8 ? `DDR3B_BL8_LAST : `DDR3B_BC4_LAST;
   wire lnkTake = lnkActive & wrBeatValid & ~lnkNewReq;
   wire lnkEnd = lnkTake & (lnkCnt == lnkLastIdx);
   always_ff @(posedge dqsClk) begin
      lnkRstSync <= {lnkRstSync[0], rst};
      reqSync <= lnkRst ? 3'h0 : {reqSync[1:0], wrReqTog};
   end
   always_ff @(posedge dqsClk) begin
      if (lnkRst) begin
         lnkActive <= 1'b0;
         lnkBl8 <= 1'b0;
         lnkCnt <= 3'h0;
         lnkBase <= '0;
      end else if (lnkNewReq) begin
         lnkActive <= 1'b1;
         lnkBl8 <= wrReqBl8;
         lnkCnt <= 3'h0;
         lnkBase <= wrReqBase;
      end else if (lnkTake) begin
         lnkActive <= ~lnkEnd;
         lnkCnt <= lnkCnt + 3'h1;
      end
   end
   always_ff @(posedge dqsClk) begin
      if (lnkTake) begin
         lnkBuf[lnkCnt] <= wrBeat;
      end
   end
   always_ff @(posedge dqsClk) begin
      if (lnkRst) begin
         lnkDoneTog <= 1'b0;
         doneBase <= '0;
         doneBl8 <= 1'b0;
      end else if (lnkEnd) begin
         lnkDoneTog <= ~lnkDoneTog;
         doneBase <= lnkBase;
         doneBl8 <= lnkBl8;
      end
   end

   // Commit finished burst into the array
   logic [2:0] doneSync;
   always_ff @(posedge mclk) begin
      doneSync <= rst ? 3'h0 : {doneSync[1:0], lnkDoneTog};
   end
   wire commit = doneSync[2] ^ doneSync[1];
   always_ff @(posedge mclk) begin
      if (commit) begin
         for (int i = 0; i < `DDR3B_BL8_BEATS; i++) begin
            for (int b = 0; b < 2; b++) begin
               if ((doneBl8 || i < `DDR3B_BC4_BEATS) && !lnkBuf[i].dm[b]) begin
                  mem[doneBase + AW'(i)][b*8 +: 8] <= lnkBuf[i].dq[b*8 +: 8];
               end
            end
         end
      end
   end

   // Checks
   logic [7:0] oldByte0;
   wire [7:0] memByte0 = mem[doneBase][7:0];
   always_ff @(posedge mclk) begin
      oldByte0 <= memByte0;
   end

   sequence bl8Data;
      rdDqOe [*4] ##1 !rdDqOe;
   endsequence
   sequence bc4Data;
      rdDqOe [*2] ##1 !rdDqOe;
   endsequence

   chk_read_latency: assert property (@(posedge mclk) disable iff (rst)
      rdFire |-> ##RL_C rdDqOe) else $error("read data not driven at read latency");
   chk_bl8_release: assert property (@(posedge mclk) disable iff (rst)
      (rdFire && isBl8) ##1 (!cmd.valid) [*4] |-> ##RL_M4 bl8Data) else $error("eight-beat read window wrong");
   chk_bc4_release: assert property (@(posedge mclk) disable iff (rst)
      (rdFire && !isBl8) ##1 (!cmd.valid) [*2] |-> ##RL_M2 bc4Data) else $error("chop-four read window wrong");
   chk_strobe_data: assert property (@(posedge mclk) disable iff (rst)
      $fell(rdDqOe) |-> !rdDqsOe && rdDq == 32'h0) else $error("strobe or data still driven");
   chk_mask_keep: assert property (@(posedge mclk) disable iff (rst)
      commit && lnkBuf[0].dm[0] |=> memByte0 == oldByte0) else $error("masked byte was overwritten");
   chk_write_size: assert property (@(posedge mclk) disable iff (rst)
      wrFire && mrBurstLen == `DDR3B_MR_OTF |=> wrReqBl8 == $past(cmd.a12)) else $error("write burst size wrong");
   chk_link_end: assert property (@(posedge dqsClk) disable iff (lnkRst)
      lnkEnd |=> !lnkActive && $changed(lnkDoneTog)) else $error("write burst did not close");
   chk_link_restart: assert property (@(posedge dqsClk) disable iff (lnkRst)
      lnkNewReq |=> lnkActive && lnkCnt == 3'h0) else $error("new write did not restart capture");
   chk_commit_follow: assert property (@(posedge mclk) disable iff (rst)
      $changed(doneSync[1]) |-> commit ##1 !commit) else $error("commit pulse wrong");
endmodule : ddr3b_burst_core

// [ddr3b_params.svh]
// Constants for the burst read and write core
`ifndef DDR3B_PARAMS_SVH
`define DDR3B_PARAMS_SVH
`define DDR3B_AL 4
`define DDR3B_CL 5
`define DDR3B_BL8_BEATS 8
`define DDR3B_BC4_BEATS 4
`define DDR3B_BL8_LAST 3'h7
`define DDR3B_BC4_LAST 3'h3
`define DDR3B_BL8_CYC 2'h3
`define DDR3B_BC4_CYC 2'h1
`define DDR3B_MR_BL8 2'h0
`define DDR3B_MR_OTF 2'h1
`define DDR3B_TRTP_NCK 4
`define DDR3B_TRTP_PS 7500
`define DDR3B_MCLK_PS 4000
`define DDR3B_TRTP_CYC (((`DDR3B_TRTP_PS + `DDR3B_MCLK_PS - 1) / `DDR3B_MCLK_PS) > `DDR3B_TRTP_NCK ? \
   ((`DDR3B_TRTP_PS + `DDR3B_MCLK_PS - 1) / `DDR3B_MCLK_PS) : `DDR3B_TRTP_NCK)
`endif

// [ddr3b_pkg.sv]
// Types shared by the burst read and write core
package ddr3b_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic a12;
      logic [2:0] bank;
      logic [9:0] col;
   } ddr3b_cmd_type;
   typedef struct packed {
      logic [15:0] dq;
      logic [1:0] dm;
   } ddr3b_beat_type;
endpackage : ddr3b_pkg

// [ddr3b_ctl_model.sv]
// Controller-side model driving the write strobe and data beats
`timescale 1ns/1ps
module ddr3b_ctl_model (
   output logic dqsClk,
   output ddr3b_pkg::ddr3b_beat_type wrBeat,
   output logic wrBeatValid
);
   import ddr3b_pkg::*;
   initial begin
      dqsClk = 1'b0;
      wrBeat = '0;
      wrBeatValid = 1'b0;
   end
   // Strobe runs only inside a frame: idle edges, beats, trailing edges
   task automatic burst(input int pre, input int n, input ddr3b_beat_type b[8]);
      #7;
      for (int k = 0; k < pre + n + 3; k++) begin
         wrBeatValid = (k >= pre) && (k < pre + n);
         wrBeat = wrBeatValid ? b[k - pre] : ~wrBeat;
         #15 dqsClk = 1'b1;
         #15 dqsClk = 1'b0;
      end
      wrBeatValid = 1'b0;
      wrBeat = ~wrBeat;
   endtask : burst
endmodule : ddr3b_ctl_model

// [test_sdram_burst_read_write_timing.sv]
// Self-checking bench for the burst read and write core
`timescale 1ns/1ps
module test_sdram_burst_read_write_timing;
   import ddr3b_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   ddr3b_cmd_type cmd = '0;
   logic [1:0] mrBurstLen = 2'h0;
   logic [31:0] rdDq;
   logic rdDqOe;
   logic rdDqsOe;
   logic dqsClk;
   ddr3b_beat_type wrBeat;
   logic wrBeatValid;
   logic [15:0] mem [128];
   ddr3b_beat_type bts [8];
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   always #2 mclk = ~mclk;
   ddr3b_burst_core i_dut (.mclk(mclk), .rst(rst), .cmd(cmd), .mrBurstLen(mrBurstLen), .rdDq(rdDq),
      .rdDqOe(rdDqOe), .rdDqsOe(rdDqsOe), .dqsClk(dqsClk), .wrBeat(wrBeat), .wrBeatValid(wrBeatValid));
   ddr3b_ctl_model i_ctl (.dqsClk(dqsClk), .wrBeat(wrBeat), .wrBeatValid(wrBeatValid));
   task automatic end_sim;
      if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic is_bl8(input logic [1:0] m, input logic a);
      return m == 2'h0 || (m == 2'h1 && a);
   endfunction : is_bl8
   // Only column commands; no row is ever precharged or reopened
   task automatic issue(input logic w, input logic a, input logic [2:0] bk, input logic [9:0] cl);
      cmd = '{1'b1, w, a, bk, cl};
      @(posedge mclk);
      #1 cmd.valid = 1'b0;
   endtask : issue
   task automatic wr(input logic a, input logic [2:0] bk, input logic [9:0] cl, input logic msk);
      logic l8;
      logic [6:0] b;
      l8 = is_bl8(mrBurstLen, a);
      b = {bk, cl[3:0] & (l8 ? 4'h8 : 4'hc)};
      for (int i = 0; i < 8; i++) begin
         bts[i] = {16'($urandom), msk ? 2'($urandom) : 2'h0};
         if (i < (l8 ? 8 : 4)) begin
            if (!bts[i].dm[0]) mem[b + i][7:0] = bts[i].dq[7:0];
            if (!bts[i].dm[1]) mem[b + i][15:8] = bts[i].dq[15:8];
         end
      end
      issue(1'b1, a, bk, cl);
      i_ctl.burst(4, l8 ? 8 : 4, bts);
      repeat (8) @(posedge mclk);
      #1;
   endtask : wr
   task automatic rd(input logic a, input logic [2:0] bk, input logic [9:0] cl);
      logic l8;
      logic e;
      logic [6:0] b;
      l8 = is_bl8(mrBurstLen, a);
      b = {bk, cl[3:0] & (l8 ? 4'h8 : 4'hc)};
      issue(1'b0, a, bk, cl);
      for (int i = 1; i <= 13; i++) begin
         @(posedge mclk);
         #1;
         // Just after edge i the outputs hold what edge i+1 samples
         e = i >= 8 && i < (l8 ? 12 : 10);
         chk(32'({rdDqOe, rdDqsOe}), 32'({e, e}));
         chk(rdDq, e ? {mem[b + 2 * (i - 8) + 1], mem[b + 2 * (i - 8)]} : 32'h0);
      end
   endtask : rd
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'ha314));
      fork
         i_ctl.burst(4, 0, bts);
         repeat (6) @(posedge mclk);
      join
      chk(32'({rdDqOe, rdDqsOe}), 32'h0);
      @(posedge mclk);
      #1 rst = 1'b0;
      // Idle strobe edges let the link domain leave reset before the first beat
      i_ctl.burst(4, 0, bts);
      @(posedge mclk);
      #1;
      for (int k = 0; k < 4; k++) begin
         wr(1'b1, 3'(k / 2), 10'(k % 2 * 8), 1'b0);
      end
      for (int it = 0; it < 16; it++) begin
         mrBurstLen = 2'(it);
         wr(1'($urandom), 3'($urandom % 2), 10'($urandom), 1'b1);
         rd(1'($urandom), 3'($urandom % 2), 10'($urandom));
         rd(1'(it), 3'(it % 2), 10'(it * 4));
      end
      end_sim();
   end
endmodule : test_sdram_burst_read_write_timing
